// ---- dv/kpli_keypad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module kpli_keypad_model (
  // Keys held down by the bench
  input  wire logic [7:0] pressed,
  // Rows towards the port
  output logic      [7:0] rows
);
  // Rows carry pull-ups, so a released row reads high, never a stale value
  assign rows = ~pressed;
endmodule // kpli_keypad_model
`default_nettype wire

// ---- dv/tb_kpli_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_kpli_top;
  import kpli_pkg::*;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic        ce      = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  kpli_addr_t  addr    = 8'h00;
  kpli_byte_t  wdata   = 8'h00;
  kpli_byte_t  rdata;
  logic [7:0]  pressed = 8'h00;
  logic [7:0]  pins;
  logic [7:0]  claimed;
  logic        hit;
  logic        irq;
  logic        wake;
  logic [15:0] vec;
  logic [3:0]  pos;
  int          miscompares = 0;
  int          num_checks  = 0;

  always #2.5 mclk = ~mclk;

  kpli_keypad_model u_pad (.pressed(pressed), .rows(pins));
  kpli_top u_dut (.mclk(mclk), .rst(rst), .ce(ce), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .sfr_hit(hit), .key_pins(pins),
    .key_line_claimed(claimed), .keypad_irq_request(irq), .irq_vector(vec),
    .irq_poll_pos(pos), .wake_request(wake));

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask

  task automatic wr_reg(input kpli_addr_t a, input kpli_byte_t d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask

  // Read data stands one cycle only, so it is sampled at the next falling edge
  task automatic rd_chk(input kpli_addr_t a, input kpli_byte_t e, input logic h);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk("rdata", rdata, e);
    chk("hit", hit, h);
  endtask

  // Keys change, then the synchroniser is given time before the flags are read
  task automatic press(input logic [7:0] p, input kpli_byte_t e);
    @(negedge mclk);
    pressed = p;
    repeat (8) @(negedge mclk);
    rd_chk(8'h9e, e, 1'b1);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    rd_chk(8'h9c, 8'h00, 1'b1);
    rd_chk(8'h9d, 8'h00, 1'b1);
    rd_chk(8'h9e, 8'h00, 1'b1);
    rd_chk(8'h9f, 8'h00, 1'b0);
    chk("vector", vec, 16'h003b);
    chk("poll", pos, 16'h0008);
    chk("irq", irq, 1'b0);
    wr_reg(8'h9d, 8'h0f);
    wr_reg(8'hb1, 8'h01);
    rd_chk(8'h9d, 8'h0f, 1'b1);
    chk("claimed", claimed, 8'h0f);
    press(8'h04, 8'h04);
    chk("irq", irq, 1'b1);
    chk("wake", wake, 1'b1);
    press(8'h00, 8'h04);
    press(8'h40, 8'h44);
    wr_reg(8'h9e, 8'hfb);
    rd_chk(8'h9e, 8'h40, 1'b1);
    chk("irq", irq, 1'b0);
    chk("wake", wake, 1'b0);
    press(8'h48, 8'h48);
    chk("irq", irq, 1'b1);
    wr_reg(8'hb1, 8'h00);
    rd_chk(8'hb1, 8'h00, 1'b1);
    chk("irq", irq, 1'b0);
    chk("wake", wake, 1'b1);
    wr_reg(8'h9e, 8'h00);
    rd_chk(8'h9e, 8'h48, 1'b1);
    press(8'h00, 8'h48);
    wr_reg(8'h9e, 8'h00);
    rd_chk(8'h9e, 8'h00, 1'b1);
    // Clock enable low: a write in that window must not land
    @(negedge mclk);
    ce = 1'b0;
    wr_reg(8'h9d, 8'hff);
    @(negedge mclk);
    ce = 1'b1;
    rd_chk(8'h9d, 8'h0f, 1'b1);
    // High detection on lines 7 and 0; idle rows are high, so both flags set at once
    wr_reg(8'h9c, 8'h81);
    press(8'h01, 8'h81);
    wr_reg(8'h9e, 8'h00);
    rd_chk(8'h9e, 8'h80, 1'b1);
    press(8'h00, 8'h81);
    rd_chk(8'h9c, 8'h81, 1'b1);
    // Reset in mid-run with flags, mask and polarity all non-zero
    @(negedge mclk);
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    rd_chk(8'h9e, 8'h00, 1'b1);
    rd_chk(8'h9c, 8'h00, 1'b1);
    rd_chk(8'h9d, 8'h00, 1'b1);
    chk("claimed", claimed, 8'h00);
    chk("irq", irq, 1'b0);
    end_of_test;
  end

  // About 150 cycles of work; the limit allows over twentyfold before calling it a hang
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
endmodule // tb_kpli_top
`default_nettype wire

// ---- src/kpli_pkg.sv ----
`default_nettype none
package kpli_pkg;
  typedef logic [7:0] kpli_byte_t;
  typedef logic [7:0] kpli_addr_t;
endpackage
`default_nettype wire

// ---- src/kpli_regs.svh ----
`ifndef KPLI_REGS_SVH
`define KPLI_REGS_SVH

// Special-function addresses
`define KPLI_ADDR_POLARITY  8'h9c
`define KPLI_ADDR_MASK      8'h9d
`define KPLI_ADDR_FLAGS     8'h9e
`define KPLI_ADDR_IRQ_EN2   8'hb1
// Global keypad enable position in the second interrupt-enable register
`define KPLI_GLOBAL_EN_BIT  0
// Reset values
`define KPLI_RST_POLARITY   8'h00
`define KPLI_RST_MASK       8'h00
`define KPLI_RST_FLAGS      8'h00
`define KPLI_RST_IRQ_EN2    8'h00
// Vector and polling position of the shared keypad request
`define KPLI_VECTOR         16'h003b
`define KPLI_POLL_POS       4'h8

`endif

// ---- src/kpli_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module kpli_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Every stage starts at the pulled-up idle level, so reset release shows no false press
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Hold the last agreed value; start high so idle pull-ups do not look like presses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_out <= '1;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // kpli_sync
`default_nettype wire

// ---- src/kpli_top.sv ----
// Overview of operation
// [RULE1] Eight keypad lines on the general port, each interrupting on high or low.
// [RULE2] Each line compares against its own polarity bit, independent of the others.
// [RULE3] Matching level sets a sticky flag; only software clears it.
// [RULE4] Flags gated by per-line mask bits, then ORed into one request.
// [RULE5] Global enable bit in second interrupt-enable register gates the request.
// [RULE6] All lines share vector 003Bh at polling position 8.
// [RULE7] A detected level wakes the device from idle and power-down.
// [RULE8] Three registers: polarity select, per-line mask, per-line flags.
// [RULE9] Flag register resets to zero.
// [RULE10] Unused lines remain usable for other purposes.
// [RULE11] Polarity 0 detects low, 1 detects high; resets to zero.
// [RULE12] Mask 0 leaves standard I/O; 1 lets flag request interrupt; resets zero.
// [RULE13] Mask register at 9Dh, polarity register at 9Ch.
// [RULE14] Cleared flag re-sets next clock while level still holds.
// [RULE15] Raw inputs synchronised before comparison.
`timescale 1ns/1ps
`default_nettype none
`include "kpli_regs.svh"
module kpli_top #(
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Special-function register port
  input  wire kpli_pkg::kpli_addr_t sfr_addr,
  input  wire kpli_pkg::kpli_byte_t sfr_wdata,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  output var kpli_pkg::kpli_byte_t  sfr_rdata,
  output logic                      sfr_hit,
  // Keypad pins of the general port
  input  wire logic [LINES-1:0]     key_pins,
  output logic [LINES-1:0]          key_line_claimed,
  // Core side
  output logic                      keypad_irq_request,
  output logic [15:0]               irq_vector,
  output logic [3:0]                irq_poll_pos,
  output logic                      wake_request
);
  import kpli_pkg::*;

  logic [LINES-1:0] keypad_polarity_select_q;
  logic [LINES-1:0] keypad_line_mask_q;
  logic [LINES-1:0] keypad_line_flags_q;
  logic [LINES-1:0] keypad_line_flags_d;
  logic             keypad_global_enable_q;
  logic [LINES-1:0] pins_sync;
  logic [LINES-1:0] level_hit;
  logic [LINES-1:0] mask_wdata;
  logic             flag_wr;
  logic             any_req;

  kpli_sync #(.W(LINES)) u_sync ( // RULE15
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .async_in (key_pins),
    .sync_out (pins_sync)
  );

  // XNOR: polarity 1 matches high, 0 matches low
  assign level_hit = ~(pins_sync ^ keypad_polarity_select_q); // RULE2 RULE11 RULE1

  assign mask_wdata = sfr_wdata[LINES-1:0];
  assign flag_wr    = sfr_wr && (sfr_addr == `KPLI_ADDR_FLAGS);

  // Registers written by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keypad_polarity_select_q <= LINES'(`KPLI_RST_POLARITY); // RULE11
      keypad_line_mask_q       <= LINES'(`KPLI_RST_MASK); // RULE12
      keypad_global_enable_q   <= 1'b0;
    end else if (ce && sfr_wr) begin
      unique case (sfr_addr)
        `KPLI_ADDR_POLARITY: keypad_polarity_select_q <= mask_wdata; // RULE13 RULE8
        `KPLI_ADDR_MASK:     keypad_line_mask_q <= mask_wdata; // RULE13 RULE8
        `KPLI_ADDR_IRQ_EN2:  keypad_global_enable_q <= sfr_wdata[`KPLI_GLOBAL_EN_BIT]; // RULE5
        default: ;
      endcase
    end
  end

  // Writing 0 clears a flag; writing 1 leaves it. A live level wins over the clear.
  always_comb begin
    keypad_line_flags_d = keypad_line_flags_q;
    if (flag_wr) begin
      keypad_line_flags_d = keypad_line_flags_q & mask_wdata; // RULE3
    end
    keypad_line_flags_d = keypad_line_flags_d | level_hit; // RULE3 RULE14
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keypad_line_flags_q <= LINES'(`KPLI_RST_FLAGS); // RULE9
    end else if (ce) begin
      keypad_line_flags_q <= keypad_line_flags_d;
    end
  end

  assign any_req = |(keypad_line_flags_q & keypad_line_mask_q); // RULE4

  // Request and wake; wake ignores the global enable so power-down exit still works
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keypad_irq_request <= 1'b0;
      wake_request       <= 1'b0;
    end else if (ce) begin
      keypad_irq_request <= any_req && keypad_global_enable_q; // RULE5 RULE4
      wake_request       <= any_req; // RULE7
    end
  end

  // Lines with a clear mask bit are left to the port's ordinary I/O use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      key_line_claimed <= '0;
    end else if (ce) begin
      key_line_claimed <= keypad_line_mask_q; // RULE10 RULE12
    end
  end

  // Fixed vector slot, shared by all eight lines
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_vector   <= 16'h0000;
      irq_poll_pos <= 4'h0;
    end else if (ce) begin
      irq_vector   <= `KPLI_VECTOR; // RULE6
      irq_poll_pos <= `KPLI_POLL_POS; // RULE6
    end
  end

  // Read port, registered; unmapped addresses read zero without a hit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (ce) begin
      sfr_hit   <= 1'b0;
      sfr_rdata <= 8'h00;
      if (sfr_rd) begin
        sfr_hit <= 1'b1;
        unique case (sfr_addr)
          `KPLI_ADDR_POLARITY: sfr_rdata <= 8'(keypad_polarity_select_q);
          `KPLI_ADDR_MASK:     sfr_rdata <= 8'(keypad_line_mask_q);
          `KPLI_ADDR_FLAGS:    sfr_rdata <= 8'(keypad_line_flags_q); // RULE8
          `KPLI_ADDR_IRQ_EN2:  sfr_rdata <= {7'h00, keypad_global_enable_q};
          default:             sfr_hit <= 1'b0;
        endcase
      end
    end
  end

  // Flag behaviour: every matching line sets its flag on the next enabled edge
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (rst) // RULE3
    ce |=> (keypad_line_flags_q & $past(level_hit)) == $past(level_hit))
    else $error("flag not set by matching level");
  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (rst) // RULE3
    !flag_wr |=> (keypad_line_flags_q & $past(keypad_line_flags_q))
      == $past(keypad_line_flags_q))
    else $error("flag dropped without software clear");
  AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (rst) // RULE3
    ce && flag_wr && !sfr_wdata[6] && !level_hit[6] |=> !keypad_line_flags_q[6])
    else $error("software clear of flag 6 ignored");
  AST_LINE_ALONE: assert property (@(posedge mclk) disable iff (rst) // RULE2
    ce && !level_hit[5] && !keypad_line_flags_q[5] |=> !keypad_line_flags_q[5])
    else $error("flag 5 set without its own level");
  // Set beats clear when both land in one cycle
  AST_RESET_CLEAR: assert property (@(posedge mclk) disable iff (rst) // RULE14
    ce && flag_wr |=> (keypad_line_flags_q & $past(level_hit)) == $past(level_hit))
    else $error("live level lost on clear");
  AST_POLARITY: assert property (@(posedge mclk) disable iff (rst) // RULE11
    ce && !keypad_polarity_select_q[3] && !pins_sync[3] |=> keypad_line_flags_q[3])
    else $error("low polarity missed low level");
  AST_POLARITY_HIGH: assert property (@(posedge mclk) disable iff (rst) // RULE11
    ce && keypad_polarity_select_q[7] && pins_sync[7] |=> keypad_line_flags_q[7])
    else $error("high polarity missed high level");

  // Request, wake and line claim
  AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (rst) // RULE5
    ce && !keypad_global_enable_q |=> !keypad_irq_request)
    else $error("request raised while global enable clear");
  AST_IRQ_CAUSE: assert property (@(posedge mclk) disable iff (rst) // RULE4
    ce && keypad_global_enable_q && (keypad_line_flags_q & keypad_line_mask_q) != 0
      |=> keypad_irq_request)
    else $error("masked flag did not raise request");
  AST_IRQ_MASKED: assert property (@(posedge mclk) disable iff (rst) // RULE4
    ce && (keypad_line_flags_q & keypad_line_mask_q) == '0 |=> !keypad_irq_request)
    else $error("request raised without a masked flag");
  AST_WAKE: assert property (@(posedge mclk) disable iff (rst) // RULE7
    $rose(wake_request) |-> $past(any_req))
    else $error("wake without pending flag");
  AST_WAKE_LEVEL: assert property (@(posedge mclk) disable iff (rst) // RULE7
    ce |=> wake_request == $past(any_req))
    else $error("wake does not follow masked flags");
  AST_CLAIMED: assert property (@(posedge mclk) disable iff (rst) // RULE10
    ce |=> key_line_claimed == $past(keypad_line_mask_q))
    else $error("claimed lines differ from mask");

  // Reset and register port
  AST_RESET_VAL: assert property (@(posedge mclk) // RULE9
    $fell(rst) |-> keypad_line_flags_q == 8'h00 && keypad_line_mask_q == 8'h00)
    else $error("register not zero after reset");
  AST_NO_FALSE_PRESS: assert property (@(posedge mclk) disable iff (rst) // RULE9
    $fell(rst) |=> keypad_line_flags_q == '0)
    else $error("flag raised by reset release");
  AST_READ_FLAGS: assert property (@(posedge mclk) disable iff (rst) // RULE8
    ce && sfr_rd && sfr_addr == `KPLI_ADDR_FLAGS
      |=> sfr_hit && sfr_rdata == 8'($past(keypad_line_flags_q)))
    else $error("flag read returned wrong data");
  AST_READ_UNMAPPED: assert property (@(posedge mclk) disable iff (rst) // RULE8
    ce && sfr_rd && !(sfr_addr inside {`KPLI_ADDR_POLARITY, `KPLI_ADDR_MASK,
      `KPLI_ADDR_FLAGS, `KPLI_ADDR_IRQ_EN2}) |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  AST_MASK_WRITE: assert property (@(posedge mclk) disable iff (rst) // RULE13
    ce && sfr_wr && sfr_addr == `KPLI_ADDR_MASK |=> keypad_line_mask_q == $past(mask_wdata))
    else $error("mask write did not land");
  AST_POLARITY_WRITE: assert property (@(posedge mclk) disable iff (rst) // RULE13
    ce && sfr_wr && sfr_addr == `KPLI_ADDR_POLARITY
      |=> keypad_polarity_select_q == $past(mask_wdata))
    else $error("polarity write did not land");
endmodule // kpli_top
`default_nettype wire
